// file: bench/drive_input_function_select_test.sv
`timescale 1ns/1ps
module drive_input_function_select_test
    import drive_select_pkg::*;
;
    logic clk = 0, rst_n = 0, reg_write = 0, reg_read = 0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, d;
    logic sh, sec, sta, stb, acc, output_shutoff, alt_set_applied, run_cmd, dir_reverse;
    logic coast_stop, ramp_stop;
    logic [11:0] term;
    logic [1:0] active_set;
    int err_count = 0, cmp_count = 0;
    // Clock at 100 ns
    initial forever #50 clk = ~clk;
    terminal_driver drv (.clk(clk), .shutoff(sh), .sec(sec), .sta(sta), .stb(stb),
        .accel(acc), .term(term));
    drive_input_function_select #(.SECOND_CYCLES(4)) uut (.clk(clk), .rst_n(rst_n),
        .output_shutoff_in(sh), .second_set_select(sec), .start_input_a(sta),
        .start_input_b(stb), .terminal_in(term), .accel_decel_active(acc),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .output_shutoff(output_shutoff),
        .active_set(active_set), .alt_set_applied(alt_set_applied), .run_cmd(run_cmd),
        .dir_reverse(dir_reverse), .coast_stop(coast_stop), .ramp_stop(ramp_stop));
    // Register port cycles
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1;
        @(posedge clk);
        reg_write <= 0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1;
        @(posedge clk);
        reg_read <= 0;
        #1 v = reg_rdata;
    endtask : rd
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // Watchdog
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        give_verdict;
    end
    // Test sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        rd(STOP_SEL_OFS, d); chk("stop_sel", 32'h270f, d);
        rd(SET_COND_OFS, d); chk("set_cond", 32'h0, d);
        rd(FUNC_CODE_BASE, d); chk("code0", 32'hff, d);
        rd(8'h40, d); chk("unmapped", 32'h0, d);
        drv.put(5'b10000, 0); cyc(5); chk("pin_shutoff", 1, output_shutoff);
        wr(8'h14, CODE_SHUTOFF); drv.put(5'b00100, 12'h020); cyc(5);
        chk("code_shutoff", 1, output_shutoff);
        chk("start_blocked", 0, run_cmd);
        drv.put(0, 0); cyc(5);
        drv.put(5'b01001, 0); cyc(5); chk("set2", SET_SECOND, active_set);
        chk("alt_now", 1, alt_set_applied);
        wr(8'h08, CODE_THIRD_SET); drv.put(5'b01001, 12'h004); cyc(5);
        chk("set3", SET_THIRD, active_set);
        wr(SET_COND_OFS, COND_CONST_SPEED); cyc(1); chk("alt_ramp", 0, alt_set_applied);
        drv.put(5'b01000, 12'h004); cyc(2); chk("alt_const", 1, alt_set_applied);
        drv.put(0, 0); cyc(5); chk("set1", SET_FIRST, active_set);
        wr(NET_SHUTOFF_OFS, 1); cyc(2); chk("net_shutoff", 1, output_shutoff);
        rd(NET_SHUTOFF_OFS, d); chk("net_reg", 1, d);
        rd(STATUS_OFS, d); chk("status", 32'h4, d);
        wr(NET_SHUTOFF_OFS, 0); cyc(2); chk("net_clear", 0, output_shutoff);
        drv.put(5'b00100, 0); cyc(5); chk("fwd", 2'b10, {run_cmd, dir_reverse});
        drv.put(5'b00010, 0); cyc(5); chk("rev", 2'b11, {run_cmd, dir_reverse});
        drv.put(5'b00110, 0); cyc(5); chk("both_stop", 0, run_cmd);
        drv.put(0, 0); cyc(5); chk("ramp", 2'b01, {coast_stop, ramp_stop});
        wr(STOP_SEL_OFS, STOP_RAMP_RUNDIR); drv.put(5'b00110, 0); cyc(5);
        chk("run_dir", 2'b11, {run_cmd, dir_reverse});
        drv.put(0, 0); cyc(5);
        for (int i = 0; i < 2; i++) begin
            wr(STOP_SEL_OFS, i ? 32'd1002 : 32'd2); drv.put(5'b00100, 0); cyc(5);
            drv.put(0, 0); cyc(6); chk("delay", 2'b01, {coast_stop, ramp_stop});
            cyc(14); chk("coast", 1, coast_stop);
        end
        give_verdict;
    end
endmodule : drive_input_function_select_test

// file: bench/drive_select_props.sv
`timescale 1ns/1ps
module drive_select_props
    import drive_select_pkg::*;
(
    // Clock, reset and pins
    input wire logic clk,
    input wire logic rst_n,
    input wire logic output_shutoff_in,
    input wire logic second_set_select,
    input wire logic start_input_a,
    input wire logic start_input_b,
    input wire logic reg_read,
    // Observed outputs
    input wire logic [31:0] reg_rdata,
    input wire logic output_shutoff,
    input wire logic [1:0] active_set,
    input wire logic alt_set_applied,
    input wire logic run_cmd,
    input wire logic dir_reverse,
    input wire logic coast_stop,
    input wire logic ramp_stop
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Held start patterns
    sequence s_fwd_held;
        (start_input_a && !start_input_b)[*4];
    endsequence
    sequence s_idle_held;
        (!start_input_a && !start_input_b)[*4];
    endsequence
    property p_shutoff; output_shutoff_in[*4] |-> output_shutoff; endproperty
    a_shutoff: assert property (p_shutoff) else $error("shutoff pin ignored");
    property p_shut_run; output_shutoff ##1 output_shutoff |-> !run_cmd; endproperty
    a_shut_run: assert property (p_shut_run) else $error("run during shutoff");
    property p_second; second_set_select[*4] |-> active_set != SET_FIRST; endproperty
    a_second: assert property (p_second) else $error("second set missing");
    property p_alt; alt_set_applied |-> active_set != SET_FIRST; endproperty
    a_alt: assert property (p_alt) else $error("alternate without select");
    property p_fwd;
        s_fwd_held |-> (run_cmd && !dir_reverse) || output_shutoff || $past(output_shutoff);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward start lost");
    property p_idle; s_idle_held |-> !run_cmd; endproperty
    a_idle: assert property (p_idle) else $error("run with starts off");
    property p_modes; run_cmd |-> !coast_stop && !ramp_stop; endproperty
    a_modes: assert property (p_modes) else $error("run and stop together");
    property p_rdata; !reg_read |=> reg_rdata == 32'h0; endproperty
    a_rdata: assert property (p_rdata) else $error("read data without read");
endmodule : drive_select_props

bind drive_input_function_select drive_select_props chk (.clk(clk), .rst_n(rst_n),
    .output_shutoff_in(output_shutoff_in), .second_set_select(second_set_select),
    .start_input_a(start_input_a), .start_input_b(start_input_b), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .output_shutoff(output_shutoff), .active_set(active_set),
    .alt_set_applied(alt_set_applied), .run_cmd(run_cmd), .dir_reverse(dir_reverse),
    .coast_stop(coast_stop), .ramp_stop(ramp_stop));

// file: bench/terminal_driver.sv
`timescale 1ns/1ps
module terminal_driver (
    // Clock
    input wire logic clk,
    // Terminal levels
    output logic shutoff,
    output logic sec,
    output logic sta,
    output logic stb,
    output logic accel,
    output logic [11:0] term
);
    // Idle controller
    initial {shutoff, sec, sta, stb, accel, term} = '0;
    // Change terminals just after an edge
    task put(input logic [4:0] p, input logic [11:0] t);
        @(posedge clk);
        {shutoff, sec, sta, stb, accel} <= p;
        term <= t;
    endtask : put
endmodule : terminal_driver

// file: verilog/drive_input_function_select.sv
// What this block does
// - Output shutoff is taken from any terminal holding code 24 as well as its own terminal.
// - An active output shutoff stops the output whatever the operation mode.
// - Second set select turns on the second set, third set select the third set.
// - With the selection condition at 0 the chosen set applies as soon as its select is on.
// - With the selection condition at 10 the chosen set applies only at constant speed.
// - Third set select is taken from any terminal holding code 9.
// - Second set select sits on its own terminal and on any terminal holding code 3.
// - A selected alternate set replaces ramp times, boost, base frequency and stall limits.
// - A select switches every function that has an alternate at once, not one item.
// - Stop selection 9999 or 0 to 100 makes input a forward start and input b reverse start.
// - Stop selection 8888 or 1000 to 1100 makes input a run and input b direction.
// - Stop selection 0 to 100 coasts the motor that many seconds after start goes off.
// - Stop selection 1000 to 1100 coasts the motor after the setting minus 1000 seconds.
// - Stop selection 9999 ramps the motor down when the start command goes off.
`timescale 1ns/1ps
module drive_input_function_select
    import drive_select_pkg::*;
#(
    parameter int SECOND_CYCLES = SECOND_CYCLES_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Dedicated and assignable input terminals
    input wire logic output_shutoff_in,
    input wire logic second_set_select,
    input wire logic start_input_a,
    input wire logic start_input_b,
    input wire logic [NUM_TERMINALS-1:0] terminal_in,
    // Drive status from the speed loop
    input wire logic accel_decel_active,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Decoded commands
    output logic output_shutoff,
    output logic [1:0] active_set,
    output logic alt_set_applied,
    output logic run_cmd,
    output logic dir_reverse,
    output logic coast_stop,
    output logic ramp_stop
);

    // Every register of the block in one record
    typedef struct packed {
        // Two-stage pin synchroniser
        logic [NUM_TERMINALS+3:0] sync1;
        logic [NUM_TERMINALS+3:0] sync2;

        // Software settings
        logic [NUM_TERMINALS-1:0][7:0] func_code;
        logic [7:0] set_cond;
        logic [13:0] stop_sel;
        logic net_shutoff;

        // Start and stop sequencer
        stop_state_t state;
        logic [6:0] delay_left;
        logic [23:0] tick;

        // Registered outputs
        logic [31:0] rdata;
        logic shutoff;
        logic [1:0] set_sel;
        logic dir_rev;
    } regs_t;

    // Current and next register record
    regs_t r;
    regs_t next_r;

    // Synchronised pin view, read only from the second flop
    logic [NUM_TERMINALS-1:0] term_sync;
    logic shutoff_pin;
    logic second_pin;
    logic start_a;
    logic start_b;

    // Function sources after terminal decoding
    logic shutoff_any;
    logic second_any;
    logic third_any;

    // Stop selection decode
    logic run_dir_mode;
    logic timed_plain;
    logic timed_offset;
    logic [6:0] delay_secs;

    // Start inputs after mode decoding
    logic start_on;
    logic start_rev;

    // Coast delay timing and status readback
    logic sec_done;
    logic [31:0] status_word;

    // True if any assignable terminal with the given code is on
    // Several terminals may carry one function; their inputs are ORed
    function automatic logic code_active(
        input logic [NUM_TERMINALS-1:0][7:0] codes,
        input logic [NUM_TERMINALS-1:0] pins,
        input logic [7:0] code
    );
        logic hit;
        hit = 1'b0;

        // A terminal counts only while its pin is on
        for (int i = 0; i < NUM_TERMINALS; i++) begin
            hit = hit | (pins[i] & (codes[i] == code));
        end

        return hit;
    endfunction : code_active

    // Assignable terminals after the second sync stage
    assign term_sync = r.sync2[NUM_TERMINALS-1:0];

    // Dedicated terminals after the second sync stage
    assign shutoff_pin = r.sync2[NUM_TERMINALS];
    assign second_pin = r.sync2[NUM_TERMINALS+1];
    assign start_a = r.sync2[NUM_TERMINALS+2];
    assign start_b = r.sync2[NUM_TERMINALS+3];

    // Function sources from terminals and software
    always_comb begin
        // Dedicated pin, communication bit and any code 24 terminal
        shutoff_any = shutoff_pin | r.net_shutoff
            | code_active(r.func_code, term_sync, CODE_SHUTOFF);

        // Dedicated pin or any code 3 terminal
        second_any = second_pin
            | code_active(r.func_code, term_sync, CODE_SECOND_SET);

        // No dedicated pin, code 9 terminals only
        third_any = code_active(r.func_code, term_sync, CODE_THIRD_SET);
    end

    // Stop selection decode
    always_comb begin
        // Plain timed coast, 0 to 100 seconds
        timed_plain = (r.stop_sel <= STOP_TIMED_MAX);

        // Offset timed coast, 1000 to 1100
        timed_offset = (r.stop_sel >= STOP_OFFSET) && (r.stop_sel <= STOP_OFFSET_MAX);

        // Run and direction inputs for the offset range and 8888
        run_dir_mode = timed_offset || (r.stop_sel == STOP_RAMP_RUNDIR);

        // Delay in seconds; both ranges fit seven bits
        if (timed_offset) begin
            delay_secs = 7'(r.stop_sel - STOP_OFFSET);
        end else begin
            delay_secs = 7'(r.stop_sel);
        end
    end

    // Start inputs into run and direction
    always_comb begin
        if (run_dir_mode) begin
            // Input a runs, input b picks reverse
            start_on = start_a;
            start_rev = start_b;
        end else begin
            // One input alone runs; both or none stop
            start_on = start_a ^ start_b;
            start_rev = start_b;
        end
    end

    // Last clock of one second of coast delay
    assign sec_done = (r.tick == 24'(SECOND_CYCLES - 1));

    // Status word layout, read only
    always_comb begin
        status_word = 32'h0;
        status_word[1:0] = r.set_sel; // Active set
        status_word[2] = r.shutoff; // Output shut off
        status_word[5:3] = r.state; // Sequencer state
        status_word[6] = r.dir_rev; // Reverse direction
        status_word[13:7] = r.delay_left; // Seconds left
    end

    // Next state of every register
    always_comb begin
        // Hold everything unless changed below
        next_r = r;

        // Pins into the first flop, first flop into the second
        next_r.sync1 = {start_input_b, start_input_a, second_set_select,
            output_shutoff_in, terminal_in};
        next_r.sync2 = r.sync1;

        // Shutoff from every source, registered once
        next_r.shutoff = shutoff_any;

        // Read data stand one cycle only, zero otherwise
        next_r.rdata = 32'h0;

        // Alternate set choice; third wins when both selects are on
        // Registered so every set item switches on one edge
        if (third_any) begin
            next_r.set_sel = SET_THIRD;
        end else if (second_any) begin
            next_r.set_sel = SET_SECOND;
        end else begin
            next_r.set_sel = SET_FIRST;
        end

        // Register writes
        if (reg_write) begin
            // Code words sit at every fourth byte below the settings
            if (reg_addr < SET_COND_OFS && reg_addr[1:0] == 2'h0) begin
                next_r.func_code[reg_addr[5:2]] = reg_wdata[7:0];
            end else begin
                // Settings words; status and unmapped writes are dropped
                case (reg_addr)
                    SET_COND_OFS: next_r.set_cond = reg_wdata[7:0];
                    STOP_SEL_OFS: next_r.stop_sel = reg_wdata[13:0];
                    NET_SHUTOFF_OFS: next_r.net_shutoff = reg_wdata[0];
                    default: next_r.net_shutoff = r.net_shutoff;
                endcase
            end
        end

        // Register reads, data in the next cycle only
        if (reg_read) begin
            // Code words read back in the low byte
            if (reg_addr < SET_COND_OFS && reg_addr[1:0] == 2'h0) begin
                next_r.rdata = {24'h0, r.func_code[reg_addr[5:2]]};
            end else begin
                // Settings and status; unmapped reads give zero
                case (reg_addr)
                    SET_COND_OFS: next_r.rdata = {24'h0, r.set_cond};
                    STOP_SEL_OFS: next_r.rdata = {18'h0, r.stop_sel};
                    NET_SHUTOFF_OFS: next_r.rdata = {31'h0, r.net_shutoff};
                    STATUS_OFS: next_r.rdata = status_word;
                    default: next_r.rdata = 32'h0;
                endcase
            end
        end

        // Coast delay counter idles at zero
        next_r.tick = 24'h0;

        // Start and stop sequencing
        case (r.state)
            // Stopped or stopping: a start runs unless shut off
            ST_IDLE, ST_COAST, ST_RAMP: begin
                if (start_on && !shutoff_any) begin
                    next_r.state = ST_RUN;
                    // Direction taken with the start
                    next_r.dir_rev = start_rev;
                end
            end

            // Running: direction follows the inputs
            ST_RUN: begin
                next_r.dir_rev = start_rev;
                if (shutoff_any) begin
                    // Shutoff always lets the motor coast
                    next_r.state = ST_COAST;
                end else if (!start_on) begin
                    if (timed_plain || timed_offset) begin
                        // Timed stop counts down before coasting
                        next_r.state = ST_DELAY;
                        next_r.delay_left = delay_secs;
                    end else begin
                        // Other settings ramp down
                        next_r.state = ST_RAMP;
                    end
                end
            end

            // Timed delay: a new start cancels it
            ST_DELAY: begin
                if (shutoff_any) begin
                    // Shutoff ends the delay at once
                    next_r.state = ST_COAST;
                end else if (start_on) begin
                    // Start again before the delay runs out
                    next_r.state = ST_RUN;
                    next_r.dir_rev = start_rev;
                end else if (r.delay_left == 7'h0) begin
                    // Delay spent, let the motor coast
                    next_r.state = ST_COAST;
                end else if (sec_done) begin
                    // One more second gone
                    next_r.delay_left = r.delay_left - 7'h1;
                end else begin
                    // Count clocks of the current second
                    next_r.tick = r.tick + 24'h1;
                end
            end

            // Unused codes fall back to stopped
            default: next_r.state = ST_IDLE;
        endcase
    end

    // State register; reset loads only constants
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Outputs, synchroniser and sequencer clear
            r <= '0;

            // Settings take their power-up values
            r.func_code <= {NUM_TERMINALS{CODE_NONE_RESET}};
            r.set_cond <= SET_COND_RESET;
            r.stop_sel <= STOP_SEL_RESET;
            r.state <= ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // Register read data
    assign reg_rdata = r.rdata;

    // Shutoff and parameter set outputs
    assign output_shutoff = r.shutoff;
    assign active_set = r.set_sel;

    // One flag switches all alternate items together
    // Condition 10 holds the alternate back while speed ramps
    assign alt_set_applied = (r.set_sel != SET_FIRST)
        && ((r.set_cond != COND_CONST_SPEED) || !accel_decel_active);

    // Run command and direction
    assign run_cmd = (r.state == ST_RUN);
    assign dir_reverse = r.dir_rev;

    // Stop method; the timed delay still shows a ramp
    assign coast_stop = (r.state == ST_COAST);
    assign ramp_stop = (r.state == ST_RAMP) || (r.state == ST_DELAY);

endmodule : drive_input_function_select

// file: verilog/drive_select_pkg.sv
package drive_select_pkg;

    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] FUNC_CODE_BASE = 8'h00;
    localparam logic [7:0] SET_COND_OFS = 8'h30;
    localparam logic [7:0] STOP_SEL_OFS = 8'h34;
    localparam logic [7:0] NET_SHUTOFF_OFS = 8'h38;
    localparam logic [7:0] STATUS_OFS = 8'h3c;

    // Terminal count and function codes
    localparam int NUM_TERMINALS = 12;
    localparam logic [7:0] CODE_SECOND_SET = 8'h03;
    localparam logic [7:0] CODE_THIRD_SET = 8'h09;
    localparam logic [7:0] CODE_SHUTOFF = 8'h18;
    localparam logic [7:0] CODE_NONE_RESET = 8'hff;

    // Selection condition values
    localparam logic [7:0] COND_IMMEDIATE = 8'h00;
    localparam logic [7:0] COND_CONST_SPEED = 8'h0a;
    localparam logic [7:0] SET_COND_RESET = COND_IMMEDIATE;

    // Stop selection values and ranges
    localparam logic [13:0] STOP_RAMP = 14'h270f;
    localparam logic [13:0] STOP_RAMP_RUNDIR = 14'h22b8;
    localparam logic [13:0] STOP_TIMED_MAX = 14'h0064;
    localparam logic [13:0] STOP_OFFSET = 14'h03e8;
    localparam logic [13:0] STOP_OFFSET_MAX = 14'h044c;
    localparam logic [13:0] STOP_SEL_RESET = STOP_RAMP;

    // Timing: the coast delay unit is one second
    localparam int CLK_HZ = 10_000_000;
    localparam int DELAY_UNIT_S = 1;
    localparam int SECOND_CYCLES_DEFAULT = CLK_HZ * DELAY_UNIT_S;

    // Parameter set selection
    localparam logic [1:0] SET_FIRST = 2'h0;
    localparam logic [1:0] SET_SECOND = 2'h1;
    localparam logic [1:0] SET_THIRD = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RUN = 3'b001,
        ST_DELAY = 3'b010,
        ST_COAST = 3'b011,
        ST_RAMP = 3'b100
    } stop_state_t;

endpackage : drive_select_pkg
